// *** design/svd_pkg.sv ***
// Package for the space vector duty calculator: constants and carrier types
package svd_pkg;

  // Data widths
  localparam int SVD_VW = 16;   // Signed alpha/beta input width
  localparam int SVD_DW = 16;   // Unsigned duty width, full scale = one period

  // Fixed-point constants (Q1.15 style, 1.0 == 2**15)
  localparam logic [15:0] SVD_HALF_SQRT3 = 16'h6ed9; // sqrt(3)/2 * 2**15
  localparam logic [15:0] SVD_FULL       = 16'h8000; // One normalised period

  // Reset values
  localparam logic [15:0] SVD_DUTY_RST   = 16'h4000; // Half period: zero output voltage
  localparam logic [2:0]  SVD_SECT_RST   = 3'h1;

  // Pipeline latency in cycles from input strobe to result ready
  localparam int SVD_LAT = 3;

  // Input voltage vector
  typedef struct packed {
    logic signed [15:0] alpha;
    logic signed [15:0] beta;
  } svd_vec_t;

  // Three phase duties
  typedef struct packed {
    logic [15:0] phase_a_duty;
    logic [15:0] phase_b_duty;
    logic [15:0] phase_c_duty;
  } svd_duty_t;

  // Compute state machine
  typedef enum logic [1:0] {
    SVD_IDLE  = 2'b00,
    SVD_AXIS  = 2'b01,
    SVD_TIME  = 2'b10,
    SVD_DONE  = 2'b11
  } svd_state_t;

endpackage

// *** design/svd_axis.sv ***
// Modified inverse Clarke transform: alpha/beta to three axis values
`timescale 1ns/1ps
module svd_axis
  import svd_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // Vector in
  input  wire svd_pkg::svd_vec_t   vec_i,
  // Axis values out, registered
  output logic signed [17:0]       axis_one_value_o,
  output logic signed [17:0]       axis_two_value_o,
  output logic signed [17:0]       axis_three_value_o
);
  import svd_pkg::*;

  logic signed [33:0] prod_ab;
  logic signed [17:0] half_beta;
  logic signed [17:0] root_alpha;

  // Half root three alpha, truncated back to input scale
  assign prod_ab    = 34'(vec_i.alpha) * 34'($signed({1'b0, SVD_HALF_SQRT3}));
  assign root_alpha = prod_ab[32:15];
  assign half_beta  = 18'(vec_i.beta) >>> 1;

  // One cycle: three axes formed together [R8]
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      axis_one_value_o   <= '0;
      axis_two_value_o   <= '0;
      axis_three_value_o <= '0;
    end else begin
      axis_one_value_o   <= 18'(vec_i.beta);          // [R8]
      axis_two_value_o   <= root_alpha - half_beta;   // [R8]
      axis_three_value_o <= -root_alpha - half_beta;  // [R8]
    end
  end

endmodule

// *** design/svd_duty_calc.sv ***
// Space vector duty calculator top: sector pick, on-times, duties, period latch
//
// Summary of operation
// [R1] Find the hexagon sector first; use only its two adjacent active vectors.
// [R2] Sector one uses patterns 100 and 110 plus both zero patterns.
// [R3] Phase duty sums bit times on-time plus all-high bit times half zero time.
// [R4] Zero time splits evenly; the all-low half adds nothing.
// [R5] First active, second active and zero times together make one period.
// [R6] Zero time is one minus both active times; lowest phase gets half of it.
// [R7] Middle phase is lowest plus second time; highest is middle plus first.
// [R8] Three axis values come from alpha and beta by modified inverse Clarke.
// [R9] Two axes bound to the sector give the active times; third points opposite.
// [R10] Bound axes map to phases per sector, chosen from the axis signs.
// [R11] Active times follow the sine-rule forms; the axis values realise them.
// [R12] Period is center aligned in seven segments, mirrored about the middle.
// [R13] Never command both switches of one leg on together.
// [R14] Clamp duties to one period and publish them only at a period boundary.
`timescale 1ns/1ps
module svd_duty_calc
  import svd_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // Voltage vector from the regulators
  input  wire svd_pkg::svd_vec_t   vec_i,
  input  wire logic                vec_valid_i,
  output logic                     vec_ready_o,
  // Period boundary from the PWM timer
  input  wire logic                period_start_i,
  // Duties to the PWM timer
  output svd_pkg::svd_duty_t       duty_o,
  output logic                     duty_update_o,
  output logic [2:0]               sector_o,
  // Phase leg commands at the given counter position
  input  wire logic [15:0]         pwm_count_i,
  output logic [2:0]               leg_high_o,
  output logic [2:0]               leg_low_o
);
  import svd_pkg::*;

  svd_state_t         state_ff;
  svd_vec_t           vec_ff;
  logic signed [17:0] ax1;
  logic signed [17:0] ax2;
  logic signed [17:0] ax3;
  logic [2:0]         sector_ff;
  logic [17:0]        t_first_ff;
  logic [17:0]        t_second_ff;
  logic [2:0]         hi_ph_ff;
  logic [2:0]         mid_ph_ff;
  svd_duty_t          calc_ff;
  logic               pend_ff;
  svd_duty_t          duty_ff;
  logic               upd_ff;
  logic [2:0]         nxt_sector;
  logic [17:0]        nxt_first;
  logic [17:0]        nxt_second;
  logic [2:0]         nxt_hi;
  logic [2:0]         nxt_mid;

  // Clamp a signed intermediate into 0..full period [R14]
  function automatic logic [15:0] clamp_duty(input logic signed [19:0] v);
    logic [15:0] r;
    r = '0;
    if (v < 0)
      r = '0;
    else if (v > 20'(SVD_FULL))
      r = SVD_FULL;
    else
      r = v[15:0];
    return r;
  endfunction

  // Positive part of an axis value; negative values floor at zero
  function automatic logic [17:0] pos_part(input logic signed [17:0] v);
    logic [17:0] r;
    r = '0;
    r = (v < 0) ? 18'h00000 : v;
    return r;
  endfunction

  svd_axis u_axis (
    .mclk_i             (mclk_i),
    .rst_i              (rst_i),
    .vec_i              (vec_ff),
    .axis_one_value_o   (ax1),
    .axis_two_value_o   (ax2),
    .axis_three_value_o (ax3)
  );

  // Accept a new vector only when idle
  assign vec_ready_o = (state_ff == SVD_IDLE);

  // Sector pick from axis signs; one-hot phase ids a=100 b=010 c=001 [R1] [R10]
  always_comb begin
    nxt_sector = SVD_SECT_RST;
    nxt_first  = '0;
    nxt_second = '0;
    nxt_hi     = 3'h4;
    nxt_mid    = 3'h2;
    case ({ax3 < 0, ax2 < 0, ax1 < 0})
      // Sector 1: vectors 100, 110; a>b>c [R2] [R9]
      3'b100: begin
        nxt_sector = 3'h1;
        nxt_first  = pos_part(ax2);
        nxt_second = pos_part(ax1);
        nxt_hi     = 3'h4;
        nxt_mid    = 3'h2;
      end
      // Sector 2: vectors 110, 010; b>a>c
      3'b110: begin
        nxt_sector = 3'h2;
        nxt_first  = pos_part(-ax2);
        nxt_second = pos_part(-ax3);
        nxt_hi     = 3'h2;
        nxt_mid    = 3'h4;
      end
      // Sector 3: vectors 010, 011; b>c>a
      3'b010: begin
        nxt_sector = 3'h3;
        nxt_first  = pos_part(ax1);
        nxt_second = pos_part(ax3);
        nxt_hi     = 3'h2;
        nxt_mid    = 3'h1;
      end
      // Sector 4: vectors 011, 001; c>b>a
      3'b011: begin
        nxt_sector = 3'h4;
        nxt_first  = pos_part(-ax1);
        nxt_second = pos_part(-ax2);
        nxt_hi     = 3'h1;
        nxt_mid    = 3'h2;
      end
      // Sector 5: vectors 001, 101; c>a>b
      3'b001: begin
        nxt_sector = 3'h5;
        nxt_first  = pos_part(ax3);
        nxt_second = pos_part(ax2);
        nxt_hi     = 3'h1;
        nxt_mid    = 3'h4;
      end
      // Sector 6: vectors 101, 100; a>c>b
      3'b101: begin
        nxt_sector = 3'h6;
        nxt_first  = pos_part(-ax3);
        nxt_second = pos_part(-ax1);
        nxt_hi     = 3'h4;
        nxt_mid    = 3'h1;
      end
      // Zero vector, no axis negative: all times zero, sector 1
      default: begin
        nxt_sector = SVD_SECT_RST;
      end
    endcase
  end

  // Sequencer: capture, axis, time, done
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= SVD_IDLE;
      vec_ff   <= '0;
    end else begin
      case (state_ff)
        SVD_IDLE: begin
          if (vec_valid_i) begin
            vec_ff   <= vec_i;
            state_ff <= SVD_AXIS;
          end
        end
        SVD_AXIS: state_ff <= SVD_TIME;
        SVD_TIME: state_ff <= SVD_DONE;
        SVD_DONE: state_ff <= SVD_IDLE;
        default:  state_ff <= SVD_IDLE;
      endcase
    end
  end

  // Register sector and active times once axes are valid [R9] [R11]
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sector_ff   <= SVD_SECT_RST;
      t_first_ff  <= '0;
      t_second_ff <= '0;
      hi_ph_ff    <= 3'h4;
      mid_ph_ff   <= 3'h2;
    end else if (state_ff == SVD_TIME) begin
      sector_ff   <= nxt_sector;   // [R1]
      t_first_ff  <= nxt_first;    // [R11]
      t_second_ff <= nxt_second;
      hi_ph_ff    <= nxt_hi;       // [R10]
      mid_ph_ff   <= nxt_mid;
    end
  end

  // Duty build; overmodulation drives zero time negative, clamp handles it
  logic signed [19:0] zero_t;
  logic signed [19:0] low_d;
  logic signed [19:0] mid_d;
  logic signed [19:0] high_d;
  assign zero_t = 20'(SVD_FULL) - 20'(t_first_ff) - 20'(t_second_ff); // [R5] [R6]
  assign low_d  = zero_t >>> 1;                  // [R4] [R6]
  assign mid_d  = low_d + 20'(t_second_ff);      // [R7] [R3]
  assign high_d = mid_d + 20'(t_first_ff);       // [R7] [R3]

  // Route lowest, middle, highest onto phases a, b, c [R10]
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      calc_ff <= {3{SVD_DUTY_RST}};
      pend_ff <= 1'b0;
    end else begin
      if (state_ff == SVD_DONE) begin
        calc_ff.phase_a_duty <= hi_ph_ff[2] ? clamp_duty(high_d) :
                                mid_ph_ff[2] ? clamp_duty(mid_d) : clamp_duty(low_d);
        calc_ff.phase_b_duty <= hi_ph_ff[1] ? clamp_duty(high_d) :
                                mid_ph_ff[1] ? clamp_duty(mid_d) : clamp_duty(low_d);
        calc_ff.phase_c_duty <= hi_ph_ff[0] ? clamp_duty(high_d) :
                                mid_ph_ff[0] ? clamp_duty(mid_d) : clamp_duty(low_d);
      end
      // A fresh result wins over a boundary in the same cycle
      if (state_ff == SVD_DONE)
        pend_ff <= 1'b1;
      else if (period_start_i)
        pend_ff <= 1'b0;
    end
  end

  // Publish only at the period boundary so a running pattern stays intact [R14]
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_ff <= {3{SVD_DUTY_RST}};
      upd_ff  <= 1'b0;
    end else begin
      upd_ff <= period_start_i && pend_ff;
      if (period_start_i && pend_ff)
        duty_ff <= calc_ff;        // [R14]
    end
  end

  assign duty_o        = duty_ff;
  assign duty_update_o = upd_ff;
  assign sector_o      = sector_ff;

  // Center aligned compare: the period opens at the top of the up-down count,
  // so the high duty phase turns on first: 000-first-second-111, mirror [R12] [R2]
  logic [2:0] leg_on_ff;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      leg_on_ff <= 3'h0;
    end else begin
      leg_on_ff[2] <= (pwm_count_i < duty_ff.phase_a_duty); // [R12]
      leg_on_ff[1] <= (pwm_count_i < duty_ff.phase_b_duty);
      leg_on_ff[0] <= (pwm_count_i < duty_ff.phase_c_duty);
    end
  end

  // Low switch is the exact complement; both on is impossible [R13]
  assign leg_high_o = leg_on_ff;
  assign leg_low_o  = ~leg_on_ff;    // [R13]

endmodule

// *** testbench/svd_pwm_timer.sv ***
// PWM timer model: triangle counter and period boundary pulse
`timescale 1ns/1ps
module svd_pwm_timer #(
  parameter int STEP = 16'h0800
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Stall from the bench
  input  wire logic        hold_i,
  // Timer outputs
  output logic [15:0]      pwm_count_o,
  output logic             period_start_o
);
  logic up_ff;
  // Centre aligned up/down count; boundary at the top so a period opens all low
  // A stall freezes the count with no boundary
  always @(negedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_count_o <= 16'h0000;
      up_ff <= 1'b1;
      period_start_o <= 1'b0;
    end else if (hold_i) begin
      period_start_o <= 1'b0;
    end else begin
      period_start_o <= up_ff && pwm_count_o == 16'h8000 - 16'(STEP);
      pwm_count_o <= up_ff ? pwm_count_o + 16'(STEP) : pwm_count_o - 16'(STEP);
      if (up_ff && pwm_count_o == 16'h8000 - 16'(STEP)) up_ff <= 1'b0;
      if (!up_ff && pwm_count_o == 16'(STEP)) up_ff <= 1'b1;
    end
  end
endmodule

// *** testbench/svd_duty_calc_sva.sv ***
// Port checker for the duty calculator, bound to the top module
`timescale 1ns/1ps
module svd_duty_calc_sva
  import svd_pkg::*;
(
  input wire logic               mclk_i,
  input wire logic               rst_i,
  input wire svd_pkg::svd_vec_t  vec_i,
  input wire logic               vec_valid_i,
  input wire logic               vec_ready_o,
  input wire logic               period_start_i,
  input wire svd_pkg::svd_duty_t duty_o,
  input wire logic               duty_update_o,
  input wire logic [2:0]         sector_o,
  input wire logic [15:0]        pwm_count_i,
  input wire logic [2:0]         leg_high_o,
  input wire logic [2:0]         leg_low_o
);
  logic        armed_ff;
  logic [15:0] da, db, dc, mx, mn;
  // Duty fields and their extremes
  assign da = duty_o.phase_a_duty;
  assign db = duty_o.phase_b_duty;
  assign dc = duty_o.phase_c_duty;
  assign mx = (da >= db && da >= dc) ? da : ((db >= dc) ? db : dc);
  assign mn = (da <= db && da <= dc) ? da : ((db <= dc) ? db : dc);
  // Armed one edge late so history never reaches into reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) armed_ff <= 1'b0;
    else armed_ff <= 1'b1;
  end
  // Phase order that each sector implies
  function automatic logic ord_ok(logic [2:0] s, logic [15:0] a, logic [15:0] b, logic [15:0] c);
    case (s)
      3'h1: return a >= b && b >= c;
      3'h2: return b >= a && a >= c;
      3'h3: return b >= c && c >= a;
      3'h4: return c >= b && b >= a;
      3'h5: return c >= a && a >= b;
      3'h6: return a >= c && c >= b;
      default: return 1'b0;
    endcase
  endfunction
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; vec_valid_i && vec_ready_o; endsequence
  sequence s_busy; !vec_ready_o [*3] ##1 vec_ready_o; endsequence
  property p_busy; s_take |=> s_busy; endproperty
  property p_excl; leg_low_o == ~leg_high_o; endproperty
  property p_leg; armed_ff |-> leg_high_o == {$past(pwm_count_i) < $past(da),
    $past(pwm_count_i) < $past(db), $past(pwm_count_i) < $past(dc)}; endproperty
  property p_cause; duty_update_o |-> $past(period_start_i); endproperty
  property p_hold; armed_ff && !duty_update_o |-> $stable(duty_o); endproperty
  property p_clamp; da <= SVD_FULL && db <= SVD_FULL && dc <= SVD_FULL; endproperty
  property p_range; sector_o >= 3'h1 && sector_o <= 3'h6; endproperty
  property p_order; duty_update_o |-> ord_ok(sector_o, da, db, dc); endproperty
  property p_center; duty_update_o && mn != 16'h0000 && mx != SVD_FULL
    |-> 17'(mx) + 17'(mn) <= 17'h08002 && 17'(mx) + 17'(mn) >= 17'h07ffe; endproperty
  a_busy: assert property (p_busy) else $error("busy span not three cycles");
  a_excl: assert property (p_excl) else $error("both switches of a leg on");
  a_leg: assert property (p_leg) else $error("leg command differs from count");
  a_cause: assert property (p_cause) else $error("update without boundary");
  a_hold: assert property (p_hold) else $error("duty moved without update");
  a_clamp: assert property (p_clamp) else $error("duty above one period");
  a_range: assert property (p_range) else $error("sector out of range");
  a_order: assert property (p_order) else $error("phase order wrong for sector");
  a_center: assert property (p_center) else $error("zero time not split evenly");
endmodule

bind svd_duty_calc svd_duty_calc_sva i_svd_duty_calc_sva (
  .mclk_i         (mclk_i),
  .rst_i          (rst_i),
  .vec_i          (vec_i),
  .vec_valid_i    (vec_valid_i),
  .vec_ready_o    (vec_ready_o),
  .period_start_i (period_start_i),
  .duty_o         (duty_o),
  .duty_update_o  (duty_update_o),
  .sector_o       (sector_o),
  .pwm_count_i    (pwm_count_i),
  .leg_high_o     (leg_high_o),
  .leg_low_o      (leg_low_o)
);

// *** testbench/svd_duty_calc_test.sv ***
// Self-checking bench for the duty calculator
`timescale 1ns/1ps
module svd_duty_calc_test;
  import svd_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  svd_vec_t    vec_i = '0;
  logic        vec_valid_i = 1'b0;
  logic        hold = 1'b0;
  logic        vec_ready_o, period_start_i, duty_update_o;
  svd_duty_t   duty_o;
  logic [2:0]  sector_o, leg_high_o, leg_low_o;
  logic [15:0] pwm_count_i;
  int          fails = 0;
  int          samples_checked = 0;
  int          k;
  int          beta_r;
  // Clock at 25 MHz
  always #20 mclk_i = ~mclk_i;
  svd_duty_calc i_svd_duty_calc (.mclk_i(mclk_i), .rst_i(rst_i), .vec_i(vec_i),
    .vec_valid_i(vec_valid_i), .vec_ready_o(vec_ready_o), .period_start_i(period_start_i),
    .duty_o(duty_o), .duty_update_o(duty_update_o), .sector_o(sector_o),
    .pwm_count_i(pwm_count_i), .leg_high_o(leg_high_o), .leg_low_o(leg_low_o));
  svd_pwm_timer i_svd_pwm_timer (.mclk_i(mclk_i), .rst_i(rst_i), .hold_i(hold),
    .pwm_count_o(pwm_count_i), .period_start_o(period_start_i));
  // Compare with a tolerance for fixed-point rounding
  task automatic chk(input logic [15:0] got, input int exp, input int tol);
    samples_checked++;
    if ($isunknown(got) || int'(got) - exp > tol || exp - int'(got) > tol) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp[15:0]);
    end
  endtask
  // Min-max centred model; sector from the phase order
  task automatic collect(input int al, input int be);
    real u[3];
    real mx, mn;
    int  n;
    u[0] = al / 1.7320508;
    u[1] = -u[0] / 2 + be / 2.0;
    u[2] = -u[0] / 2 - be / 2.0;
    mx = u[0];
    mn = u[0];
    for (int i = 1; i < 3; i++) begin
      if (u[i] > mx) mx = u[i];
      if (u[i] < mn) mn = u[i];
    end
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (duty_update_o !== 1'b1 && n < 300);
    if (n >= 300) fails++;
    for (int i = 0; i < 3; i++) begin
      u[i] = 16384.0 + u[i] - (mx + mn) / 2;
      u[i] = u[i] < 0 ? 0 : (u[i] > 32768 ? 32768 : u[i]);
      chk(duty_o[47 - 16 * i -: 16], $rtoi(u[i] + 0.5), 8);
    end
    n = u[0] >= u[1] ? (u[1] >= u[2] ? 1 : (u[0] >= u[2] ? 6 : 5))
                     : (u[0] >= u[2] ? 2 : (u[1] >= u[2] ? 3 : 4));
    chk({13'h0000, sector_o}, n, 0);
  endtask
  // Offer a vector; optionally keep a rival offered for the first two busy cycles
  task automatic take(input int al, input int be, input bit rival);
    int n = 0;
    while (vec_ready_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    vec_i = {16'(al), 16'(be)};
    vec_valid_i = 1'b1;
    @(negedge mclk_i);
    vec_i = ~vec_i;
    vec_valid_i = rival;
    repeat (2) @(negedge mclk_i);
    vec_valid_i = 1'b0;
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the expected run of well under a thousand cycles
  initial begin
    #(40 * 20000);
    fails++;
    finish_test();
  end
  initial begin
    void'($urandom(36839));
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    chk(duty_o[31:16], SVD_DUTY_RST, 0);
    chk({13'h0000, leg_low_o}, 7, 0);
    for (k = 0; k < 6; k++) begin
      take($rtoi(12288 * $cos((20 + 60 * k) * 0.0174533)),
           $rtoi(12288 * $sin((20 + 60 * k) * 0.0174533)), 0);
      collect($rtoi(12288 * $cos((20 + 60 * k) * 0.0174533)),
              $rtoi(12288 * $sin((20 + 60 * k) * 0.0174533)));
    end
    $display("sector sweep done");
    take(16'h2000, -16'h1000, 1);
    collect(16'h2000, -16'h1000);
    take(16'h7000, 16'h7000, 0);
    collect(16'h7000, 16'h7000);
    $display("refusal and clamp done");
    repeat (10) begin
      k = $urandom_range(20480) - 10240;
      beta_r = 16'h0101 | $urandom_range(10240);
      take(k, beta_r, 0);
      collect(k, beta_r);
    end
    $display("random vectors done");
    hold = 1'b1;
    take(16'h1800, 16'h0900, 0);
    take(-16'h1400, -16'h0700, 0);
    repeat (40) begin
      @(negedge mclk_i);
      chk({15'h0000, duty_update_o}, 0, 0);
    end
    hold = 1'b0;
    collect(-16'h1400, -16'h0700);
    $display("stalled timer done");
    finish_test();
  end
endmodule
